// file: rtl/sgc_cfg.svh
// constants for the switch global control bank: offsets, field positions,
// reset values and storm period timing
// assumes a 10 MHz system clock; included by bare name
`ifndef SGC_CFG_SVH
`define SGC_CFG_SVH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define SGC_OFS_FWD_CTL        8'h05
`define SGC_OFS_HOST_STORM_HI  8'h06
`define SGC_OFS_STORM_LO       8'h07
`define SGC_OFS_FACTORY_A      8'h08
`define SGC_OFS_FACTORY_B      8'h09

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define SGC_BIT_VLAN_EN        7
`define SGC_BIT_IGMP_SNOOP     6
`define SGC_BIT_DIRECT_MODE    5
`define SGC_BIT_PRE_TAG        4
`define SGC_BIT_TAG_MASK       1
`define SGC_BIT_SNIFF_AND      0
`define SGC_BIT_BACK_PRESSURE  7
`define SGC_BIT_HALF_DUPLEX    6
`define SGC_BIT_FLOW_CTL       5
`define SGC_BIT_SLOW_RATE      4
`define SGC_BIT_NULL_VID_REPL  3
`define SGC_STORM_HI_MSB       2
`define SGC_FWD_CTL_RW_MASK    8'hF3
`define SGC_TAG_MASK_W         5
`define SGC_VID_W              12
`define SGC_STORM_W            11

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define SGC_RST_FWD_CTL        8'h00
`define SGC_RST_HOST_STORM_HI  8'h00
`define SGC_RST_STORM_LO       8'h4A
`define SGC_RST_FACTORY_A      8'h00
`define SGC_RST_FACTORY_B      8'h4C
`define SGC_RST_UNMAPPED       8'h00

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define SGC_CLK_KHZ            10000
`define SGC_FAST_PERIOD_MS     50
`define SGC_SLOW_PERIOD_MS     500
`define SGC_FAST_PERIOD_CYC    (`SGC_FAST_PERIOD_MS * `SGC_CLK_KHZ)
`define SGC_SLOW_PERIOD_CYC    (`SGC_SLOW_PERIOD_MS * `SGC_CLK_KHZ)
`define SGC_PERIOD_CNT_W       23
`define SGC_SYNC_STAGES        2'h2

`endif

// file: rtl/sgc_pkg.sv
// types shared by the switch global control bank and its storm limiter
// assumes sgc_cfg.svh supplies the widths
`include "sgc_cfg.svh"

package sgc_pkg;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef logic [7:0]                 sgc_byte_t;
  typedef logic [`SGC_STORM_W-1:0]    sgc_storm_t;
  typedef logic [`SGC_VID_W-1:0]      sgc_vid_t;
  typedef logic [`SGC_PERIOD_CNT_W-1:0] sgc_period_t;

  typedef enum logic [1:0] {
    SGC_STRAP_SYNC,
    SGC_STRAP_LOAD,
    SGC_STRAP_RUN
  } sgc_strap_e;

endpackage : sgc_pkg

// file: rtl/sgc_storm_if.sv
// carrier between the control bank and the storm limiter
// assumes one clock domain for both ends
`timescale 1ns/1ns

interface sgc_storm_if
  import sgc_pkg::*;
#(
  parameter int NUM_PORTS = 4
);
  sgc_storm_t           limit;
  logic [NUM_PORTS-1:0] block_in;
  logic [NUM_PORTS-1:0] port_slow;
  logic [NUM_PORTS-1:0] over_limit;

  modport bank  (output limit, output block_in, output port_slow, input over_limit);
  modport storm (input limit, input block_in, input port_slow, output over_limit);
endinterface : sgc_storm_if

// file: rtl/sgc_storm.sv
// per-port broadcast storm limiter: counts 64-byte blocks in a measuring period
// assumes block_in is a one-cycle pulse per broadcast block on the same clock
`timescale 1ns/1ns
`include "sgc_cfg.svh"

module sgc_storm
  import sgc_pkg::*;
#(
  parameter int unsigned NUM_PORTS  = 4,
  parameter int unsigned FAST_CYC   = `SGC_FAST_PERIOD_CYC,
  parameter int unsigned SLOW_CYC   = `SGC_SLOW_PERIOD_CYC
) (
  input  wire logic   clk_sys,
  input  wire logic   reset_n,
  sgc_storm_if.storm  sif
);

  // ------------------------------------------------------------------
  // period and block count end values
  // ------------------------------------------------------------------
  localparam sgc_period_t FAST_LAST = sgc_period_t'(FAST_CYC - 1);
  localparam sgc_period_t SLOW_LAST = sgc_period_t'(SLOW_CYC - 1);
  localparam sgc_storm_t  BLK_MAX   = '1;

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      sgc_period_t period_q;
      sgc_storm_t  blocks_q;
      wire sgc_period_t last_w = sif.port_slow[p] ? SLOW_LAST : FAST_LAST;
      // >= so a drop to the shorter period closes the long one at once
      wire         wrap_w   = (period_q >= last_w);
      wire         sat_w    = (blocks_q == BLK_MAX);

      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          period_q <= '0;
          blocks_q <= '0;
        end else if (wrap_w) begin
          period_q <= '0;
          blocks_q <= '0;
        end else begin
          period_q <= period_q + 1'b1;
          if (sif.block_in[p] && !sat_w) begin
            blocks_q <= blocks_q + 1'b1;
          end
        end
      end

      assign sif.over_limit[p] = (blocks_q >= sif.limit);
    end
  endgenerate

endmodule : sgc_storm

// file: rtl/sgc_bank.sv
// switch global control bank: forwarding, host port and storm limit controls
// assumes a byte-wide management port on clk_sys and strap pins from outside
`timescale 1ns/1ns
`include "sgc_cfg.svh"

// Functional notes
// - vlan bit turns 802.1q mode on
// - snoop bit sends igmp packets to host
// - direct mode: preamble decides, lookup skipped
// - pre-tag: host packets carry source port
// - tag mask: low vid bits pick ports
// - tag mask acts only with vlan off
// - sniff mode: one means and match
// - back-pressure bit enables host half-duplex backpressure
// - duplex bit: one half, zero full
// - flow-control bit enables host flow control
// - speed bit: one slow, zero fast
// - duplex, flow, speed load from straps
// - null vid replaced by port vid
// - eleven-bit storm limit, high bits split
// - period 50ms fast, 500ms slow
module sgc_bank
  import sgc_pkg::*;
#(
  parameter int unsigned NUM_PORTS = 4,
  parameter int unsigned FAST_CYC  = `SGC_FAST_PERIOD_CYC,
  parameter int unsigned SLOW_CYC  = `SGC_SLOW_PERIOD_CYC
) (
  input  wire logic                        clk_sys,
  input  wire logic                        reset_n,
  // management register port
  input  wire logic [7:0]                  reg_addr,
  input  wire logic                        reg_wr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_rd,
  output logic      [7:0]                  reg_rdata,
  output logic                             reg_rvalid,
  // strap pins
  input  wire logic                        duplex_strap_pin,
  input  wire logic                        flow_ctl_strap_pin,
  input  wire logic                        speed_strap_pin,
  // forwarding decisions
  input  wire logic                        pkt_is_igmp,
  output logic                             igmp_to_host,
  input  wire logic                        sniff_src_hit,
  input  wire logic                        sniff_dst_hit,
  output logic                             sniff_mirror,
  input  wire logic [`SGC_VID_W-1:0]       rx_vid,
  input  wire logic [`SGC_VID_W-1:0]       port_vid,
  output logic      [`SGC_VID_W-1:0]       vid_out,
  output logic                             tag_mask_active,
  output logic      [`SGC_TAG_MASK_W-1:0]  tag_egress_mask,
  // storm protection
  input  wire logic [NUM_PORTS-1:0]        storm_block_in,
  input  wire logic [NUM_PORTS-1:0]        storm_port_slow,
  output logic      [NUM_PORTS-1:0]        storm_drop,
  // control levels to the fabric
  output logic                             vlan_en,
  output logic                             direct_mode,
  output logic                             lookup_bypass,
  output logic                             host_pretag_en,
  output logic                             host_back_pressure,
  output logic                             host_half_duplex,
  output logic                             host_flow_ctl,
  output logic                             host_slow_rate,
  output logic      [`SGC_STORM_W-1:0]     storm_limit
);

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  sgc_byte_t  fwd_ctl_q;
  sgc_byte_t  host_storm_hi_q;
  sgc_byte_t  storm_lo_q;
  sgc_byte_t  rdata_q;
  logic       rvalid_q;
  sgc_strap_e strap_st_q;
  logic [1:0] strap_cnt_q;
  logic [2:0] strap_meta_q;
  logic [2:0] strap_sync_q;

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  wire hit_fwd_w     = (reg_addr == `SGC_OFS_FWD_CTL);
  wire hit_host_w    = (reg_addr == `SGC_OFS_HOST_STORM_HI);
  wire hit_lo_w      = (reg_addr == `SGC_OFS_STORM_LO);
  wire hit_fact_a_w  = (reg_addr == `SGC_OFS_FACTORY_A);
  wire hit_fact_b_w  = (reg_addr == `SGC_OFS_FACTORY_B);
  wire wr_fwd_w      = reg_wr && hit_fwd_w;
  wire wr_host_w     = reg_wr && hit_host_w;
  wire wr_lo_w       = reg_wr && hit_lo_w;
  wire strap_load_w  = (strap_st_q == SGC_STRAP_LOAD);

  // reserved bits of the forwarding register never take a write
  wire sgc_byte_t fwd_wr_val_w = reg_wdata & `SGC_FWD_CTL_RW_MASK;

  wire sgc_byte_t rd_mux_w =
    hit_fwd_w    ? fwd_ctl_q :
    hit_host_w   ? host_storm_hi_q :
    hit_lo_w     ? storm_lo_q :
    hit_fact_a_w ? `SGC_RST_FACTORY_A :
    hit_fact_b_w ? `SGC_RST_FACTORY_B :
                   `SGC_RST_UNMAPPED;

  // ------------------------------------------------------------------
  // strap synchroniser
  // ------------------------------------------------------------------
  // first stage is read only by the second stage
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      strap_meta_q <= 3'h0;
      strap_sync_q <= 3'h0;
    end else begin
      strap_meta_q <= {duplex_strap_pin, flow_ctl_strap_pin, speed_strap_pin};
      strap_sync_q <= strap_meta_q;
    end
  end

  // ------------------------------------------------------------------
  // strap capture sequence
  // ------------------------------------------------------------------
  // waits for the synchroniser to fill, then loads once after release
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      strap_st_q  <= SGC_STRAP_SYNC;
      strap_cnt_q <= 2'h0;
    end else begin
      unique case (strap_st_q)
        SGC_STRAP_SYNC: begin
          strap_cnt_q <= strap_cnt_q + 2'h1;
          if (strap_cnt_q == (`SGC_SYNC_STAGES - 2'h1)) begin
            strap_st_q <= SGC_STRAP_LOAD;
          end
        end
        SGC_STRAP_LOAD: begin
          strap_st_q <= SGC_STRAP_RUN;
        end
        SGC_STRAP_RUN: begin
          strap_st_q <= SGC_STRAP_RUN;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // forwarding control register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fwd_ctl_q <= `SGC_RST_FWD_CTL;
    end else if (wr_fwd_w) begin
      fwd_ctl_q <= fwd_wr_val_w;
    end
  end

  // ------------------------------------------------------------------
  // host port and storm high register
  // ------------------------------------------------------------------
  // strap load wins over a write in the same cycle; software should wait
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      host_storm_hi_q <= `SGC_RST_HOST_STORM_HI;
    end else if (strap_load_w) begin
      host_storm_hi_q[`SGC_BIT_HALF_DUPLEX] <= strap_sync_q[2];
      host_storm_hi_q[`SGC_BIT_FLOW_CTL]    <= strap_sync_q[1];
      host_storm_hi_q[`SGC_BIT_SLOW_RATE]   <= strap_sync_q[0];
    end else if (wr_host_w) begin
      host_storm_hi_q <= reg_wdata;
    end
  end

  // ------------------------------------------------------------------
  // storm low register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      storm_lo_q <= `SGC_RST_STORM_LO;
    end else if (wr_lo_w) begin
      storm_lo_q <= reg_wdata;
    end
  end

  // ------------------------------------------------------------------
  // read port
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        rdata_q <= rd_mux_w;
      end
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;

  // ------------------------------------------------------------------
  // control levels
  // ------------------------------------------------------------------
  // the vlan table must already be valid when this rises; not checked here
  assign vlan_en            = fwd_ctl_q[`SGC_BIT_VLAN_EN];
  assign direct_mode        = fwd_ctl_q[`SGC_BIT_DIRECT_MODE];
  assign lookup_bypass      = fwd_ctl_q[`SGC_BIT_DIRECT_MODE];
  assign host_pretag_en     = fwd_ctl_q[`SGC_BIT_PRE_TAG];
  assign host_back_pressure = host_storm_hi_q[`SGC_BIT_BACK_PRESSURE];
  assign host_half_duplex   = host_storm_hi_q[`SGC_BIT_HALF_DUPLEX];
  // flow control only means something in full duplex; the mac decides
  assign host_flow_ctl      = host_storm_hi_q[`SGC_BIT_FLOW_CTL];
  assign host_slow_rate     = host_storm_hi_q[`SGC_BIT_SLOW_RATE];
  assign storm_limit        = {host_storm_hi_q[`SGC_STORM_HI_MSB:0], storm_lo_q};

  // ------------------------------------------------------------------
  // per-packet decisions
  // ------------------------------------------------------------------
  // combinational so the lookup engine sees them in its own cycle
  wire snoop_en_w   = fwd_ctl_q[`SGC_BIT_IGMP_SNOOP];
  wire sniff_and_w  = fwd_ctl_q[`SGC_BIT_SNIFF_AND];
  wire null_repl_w  = host_storm_hi_q[`SGC_BIT_NULL_VID_REPL];
  wire vid_null_w   = (rx_vid == '0);

  assign igmp_to_host    = snoop_en_w && pkt_is_igmp;
  assign sniff_mirror    = sniff_and_w ? (sniff_src_hit && sniff_dst_hit)
                                       : (sniff_src_hit || sniff_dst_hit);
  assign tag_mask_active = fwd_ctl_q[`SGC_BIT_TAG_MASK] && !fwd_ctl_q[`SGC_BIT_VLAN_EN];
  assign tag_egress_mask = tag_mask_active ? rx_vid[`SGC_TAG_MASK_W-1:0] : '0;
  assign vid_out         = (null_repl_w && vid_null_w) ? port_vid : rx_vid;

  // ------------------------------------------------------------------
  // storm limiter
  // ------------------------------------------------------------------
  sgc_storm_if #(.NUM_PORTS(NUM_PORTS)) storm_bus ();

  assign storm_bus.limit     = storm_limit;
  assign storm_bus.block_in  = storm_block_in;
  assign storm_bus.port_slow = storm_port_slow;
  assign storm_drop          = storm_bus.over_limit;

  sgc_storm #(
    .NUM_PORTS (NUM_PORTS),
    .FAST_CYC  (FAST_CYC),
    .SLOW_CYC  (SLOW_CYC)
  ) u_storm (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .sif       (storm_bus)
  );

endmodule : sgc_bank

// file: test/sgc_bank_assertions.sv
// checker for the switch global control bank, sees top ports only
// assumes the bank answers reads one cycle later and loads straps at the third edge
`timescale 1ns/1ns

module sgc_bank_assertions
  import sgc_pkg::*;
#(
  parameter int unsigned NUM_PORTS = 4
) (
  input wire logic                 clk_sys,
  input wire logic                 reset_n,
  input wire logic [7:0]           reg_addr,
  input wire logic                 reg_wr,
  input wire logic [7:0]           reg_wdata,
  input wire logic                 reg_rd,
  input wire logic [7:0]           reg_rdata,
  input wire logic                 reg_rvalid,
  input wire logic                 duplex_strap_pin,
  input wire logic                 flow_ctl_strap_pin,
  input wire logic                 speed_strap_pin,
  input wire logic                 pkt_is_igmp,
  input wire logic                 igmp_to_host,
  input wire logic                 sniff_src_hit,
  input wire logic                 sniff_dst_hit,
  input wire logic                 sniff_mirror,
  input wire logic [11:0]          rx_vid,
  input wire logic [11:0]          port_vid,
  input wire logic [11:0]          vid_out,
  input wire logic                 tag_mask_active,
  input wire logic [4:0]           tag_egress_mask,
  input wire logic [NUM_PORTS-1:0] storm_drop,
  input wire logic                 vlan_en,
  input wire logic                 direct_mode,
  input wire logic                 lookup_bypass,
  input wire logic                 host_pretag_en,
  input wire logic                 host_back_pressure,
  input wire logic                 host_half_duplex,
  input wire logic                 host_flow_ctl,
  input wire logic                 host_slow_rate,
  input wire logic [10:0]          storm_limit
);
  // ----
  // age since reset; a write at the strap load edge is lost
  // ----
  logic [1:0] age_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) age_q <= 2'h0;
    else if (age_q != 2'h3) age_q <= age_q + 2'h1;
  end
  wire wr5 = reg_wr && reg_addr == 8'h05;
  wire wr6 = reg_wr && reg_addr == 8'h06 && age_q == 2'h3;
  wire wr7 = reg_wr && reg_addr == 8'h07;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ----
  // properties
  // ----
  property p_vlan; wr5 |=> vlan_en == $past(reg_wdata[7]); endproperty
  a_vlan: assert property (p_vlan) else $error("vlan enable not taken from write");
  property p_snoop; wr5 |=> igmp_to_host == ($past(reg_wdata[6]) && pkt_is_igmp); endproperty
  a_snoop: assert property (p_snoop) else $error("igmp redirect wrong");
  property p_direct;
    wr5 |=> direct_mode == $past(reg_wdata[5]) && lookup_bypass == direct_mode && host_pretag_en == $past(reg_wdata[4]);
  endproperty
  a_direct: assert property (p_direct) else $error("direct or pretag level wrong");
  property p_tagact; wr5 |=> tag_mask_active == ($past(reg_wdata[1]) && !$past(reg_wdata[7])); endproperty
  a_tagact: assert property (p_tagact) else $error("tag mask active wrong");
  property p_mask; tag_mask_active |-> !vlan_en && tag_egress_mask == rx_vid[4:0]; endproperty
  a_mask: assert property (p_mask) else $error("egress mask not from vid");
  property p_sniff;
    wr5 |=> sniff_mirror == ($past(reg_wdata[0]) ? sniff_src_hit && sniff_dst_hit : sniff_src_hit || sniff_dst_hit);
  endproperty
  a_sniff: assert property (p_sniff) else $error("sniff match wrong");
  property p_host;
    wr6 |=> {host_back_pressure, host_half_duplex, host_flow_ctl, host_slow_rate} == $past(reg_wdata[7:4]);
  endproperty
  a_host: assert property (p_host) else $error("host port bits wrong");
  property p_strap;
    age_q == 2'h2 |=> {host_half_duplex, host_flow_ctl, host_slow_rate} ==
      {$past(duplex_strap_pin, 3), $past(flow_ctl_strap_pin, 3), $past(speed_strap_pin, 3)};
  endproperty
  a_strap: assert property (p_strap) else $error("strap default not loaded");
  property p_vid;
    wr6 |=> vid_out == (($past(reg_wdata[3]) && rx_vid == 12'h000) ? port_vid : rx_vid);
  endproperty
  a_vid: assert property (p_vid) else $error("null vid handling wrong");
  property p_stlo; wr7 |=> storm_limit[7:0] == $past(reg_wdata); endproperty
  a_stlo: assert property (p_stlo) else $error("storm limit low byte wrong");
  property p_ro; reg_rd && reg_addr == 8'h09 |=> reg_rvalid && reg_rdata == 8'h4C; endproperty
  a_ro: assert property (p_ro) else $error("factory register read wrong");
  c_mask: cover property (wr5 && reg_wdata[1] && !reg_wdata[7]);
  c_drop: cover property ($rose(storm_drop[0]));
  c_ro: cover property (reg_rd && reg_addr == 8'h09);
endmodule : sgc_bank_assertions

bind sgc_bank sgc_bank_assertions #(.NUM_PORTS(NUM_PORTS)) u_chk (.*);

// file: test/sgc_mgmt_host.sv
// management host model driving the byte-wide register port
// assumes the bank samples at the rising edge; this model moves at the falling edge
`timescale 1ns/1ns

module sgc_mgmt_host (
  input  wire logic       clk_sys,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // released lines show the inverse, never the stale value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    ok = reg_rvalid;
  endtask : rd
endmodule : sgc_mgmt_host

// file: test/test_switch_global_control_bank.sv
// self-checking bench for the switch global control bank
// assumes short storm periods of 20 and 200 cycles
`timescale 1ns/1ns

module test_switch_global_control_bank
  import sgc_pkg::*;
;
  logic clk_sys = 1'b0, reset_n = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_q;
  logic reg_wr, reg_rd, reg_rvalid, ok;
  logic duplex_strap_pin = 1'b1, flow_ctl_strap_pin = 1'b0, speed_strap_pin = 1'b1;
  logic pkt_is_igmp = 1'b0, igmp_to_host, sniff_src_hit = 1'b0, sniff_dst_hit = 1'b0, sniff_mirror;
  logic [11:0] rx_vid = 12'h000, port_vid = 12'h5A3, vid_out;
  logic tag_mask_active;
  logic [4:0] tag_egress_mask;
  logic [3:0] storm_block_in = 4'h0, storm_port_slow = 4'h0, storm_drop;
  logic vlan_en, direct_mode, lookup_bypass, host_pretag_en, host_back_pressure;
  logic host_half_duplex, host_flow_ctl, host_slow_rate;
  logic [10:0] storm_limit;
  int err_total = 0, cmp_count = 0, n;
  always #50 clk_sys = ~clk_sys;
  sgc_bank #(.NUM_PORTS(4), .FAST_CYC(20), .SLOW_CYC(200)) dut (.*);
  sgc_mgmt_host u_host (.*);
  // ----
  // shared helpers
  // ----
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    u_host.rd(a, rd_q, ok);
    cmp({15'h0000, ok}, 16'h1, "read valid");
    cmp({8'h00, rd_q}, {8'h00, exp}, "read data");
  endtask : rchk
  // one full low then high of the drop flag; sum is the period
  task automatic fall_gap(output int g);
    g = 0;
    while (storm_drop[0] !== 1'b1 && g < 1000) begin @(negedge clk_sys); g++; end
    while (storm_drop[0] !== 1'b0 && g < 1000) begin @(negedge clk_sys); g++; end
  endtask : fall_gap
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  // ----
  // scenarios
  // ----
  task automatic t_reset;
    logic [7:0] a [6] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A};
    logic [7:0] e [6] = '{8'h00, 8'h50, 8'h4A, 8'h00, 8'h4C, 8'h00};
    cmp({13'h0, host_half_duplex, host_flow_ctl, host_slow_rate}, 16'h5, "straps");
    cmp({5'h0, storm_limit}, 16'h04A, "storm limit default");
    for (int i = 0; i < 6; i++) rchk(a[i], e[i]);
  endtask : t_reset
  task automatic t_readonly;
    u_host.wr(8'h08, 8'hFF);
    u_host.wr(8'h09, 8'hFF);
    u_host.wr(8'h0A, 8'hFF);
    u_host.wr(8'h05, 8'hFF);
    rchk(8'h08, 8'h00);
    rchk(8'h09, 8'h4C);
    rchk(8'h0A, 8'h00);
    rchk(8'h05, 8'hF3);
  endtask : t_readonly
  task automatic t_forward;
    // vlan table assumed filled before enabling; mask only used with vlan off
    u_host.wr(8'h05, 8'h82);
    cmp({14'h0, vlan_en, tag_mask_active}, 16'h2, "vlan on, mask idle");
    u_host.wr(8'h05, 8'h02);
    rx_vid = 12'hABC;
    #1 cmp({11'h0, tag_egress_mask}, 16'h1C, "egress mask");
    cmp({15'h0, vlan_en}, 16'h0, "vlan off");
    u_host.wr(8'h05, 8'h70);
    pkt_is_igmp = 1'b1;
    #1 cmp({12'h0, igmp_to_host, direct_mode, lookup_bypass, host_pretag_en}, 16'hF, "snoop direct pretag");
    u_host.wr(8'h05, 8'h00);
    cmp({12'h0, igmp_to_host, direct_mode, lookup_bypass, host_pretag_en}, 16'h0, "all off");
  endtask : t_forward
  task automatic t_sniff;
    for (int m = 0; m < 8; m++) begin
      u_host.wr(8'h05, {7'h00, m[2]});
      {sniff_src_hit, sniff_dst_hit} = m[1:0];
      #1 cmp({15'h0, sniff_mirror}, {15'h0, m[2] ? &m[1:0] : |m[1:0]}, "sniff");
    end
  endtask : t_sniff
  task automatic t_host;
    for (int i = 0; i < 4; i++) begin
      u_host.wr(8'h06, 8'h80 >> i);
      cmp({12'h0, host_back_pressure, host_half_duplex, host_flow_ctl, host_slow_rate}, 16'h8 >> i, "host");
    end
    u_host.wr(8'h06, 8'h08);
    rx_vid = 12'h000;
    #1 cmp({4'h0, vid_out}, 16'h5A3, "null vid replaced");
    rx_vid = 12'h001;
    #1 cmp({4'h0, vid_out}, 16'h001, "vid kept");
    u_host.wr(8'h06, 8'h00);
    rx_vid = 12'h000;
    #1 cmp({4'h0, vid_out}, 16'h000, "null vid kept");
  endtask : t_host
  task automatic t_storm;
    u_host.wr(8'h06, 8'h01);
    u_host.wr(8'h07, 8'h23);
    cmp({5'h0, storm_limit}, 16'h0123, "storm limit split");
    u_host.wr(8'h06, 8'h00);
    u_host.wr(8'h07, 8'h03);
    storm_block_in = 4'h1;
    fall_gap(n);
    fall_gap(n);
    cmp(n[15:0], 16'd20, "fast period");
    cmp({13'h0, storm_drop[3:1]}, 16'h0, "idle ports");
    storm_port_slow = 4'h1;
    fall_gap(n);
    fall_gap(n);
    cmp(n[15:0], 16'd200, "slow period");
    storm_block_in = 4'h0;
  endtask : t_storm
  // ----
  // main sequence and watchdog
  // ----
  initial begin
    repeat (12) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (5) @(negedge clk_sys);
    t_reset();
    t_readonly();
    t_forward();
    t_sniff();
    t_host();
    t_storm();
    close_out();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    close_out();
  end
endmodule : test_switch_global_control_bank
